// ---- rtl/card_interrupt_status_logic.sv ----
// Purpose: Event flags, alert pin, status, clock routing, power-down
// Assumes: AHB-Lite slave, zero wait states, word accesses only
// Notes:   Analogue comparators sit outside; their results are pins
`timescale 1ns/1ps
`include "card_alert_defs.svh"

module card_interrupt_status_logic #(
	parameter int ANSWER_LIMIT = `ANSWER_LIMIT, // Card clocks to overflow
	parameter int CARD_DIV     = `CARD_CLK_DIV  // Half period in hclk
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Pins from outside the clock domain
	input  wire logic        addr_or_host_clock_in,
	input  wire logic [1:0]  card_detect_in,
	input  wire logic [4:0]  supply_in_range,
	input  wire logic [4:0]  supply_fault_in,
	input  wire logic        slot1_overcurrent_in,
	input  wire logic        boost_b_in_range,
	input  wire logic [4:0]  card_io_line,
	input  wire logic [1:0]  aux_host_a_in,
	input  wire logic [1:0]  aux_host_b_in,
	// Shared alert pin, open-drain
	output logic             alert_n_o,
	output logic             alert_oe_n,
	// Card side outputs
	output logic      [4:0]  card_clock_line,
	output logic      [1:0]  aux_contact_a,
	output logic      [1:0]  aux_contact_b,
	output logic      [9:0]  clk_slew_code,
	output logic      [9:0]  io_rise_slew_code,
	// Supply control outputs
	output logic      [9:0]  supply_select_field,
	output logic      [1:0]  boost_b_select_field,
	output logic             conv_a_off,
	output logic             conv_b_off,
	output logic             regulator_off,
	// Latched bus address bit
	output logic             bus_addr_bit
);

	// Synchronised pins
	logic       host_lvl, host_rise;        // Shared address/clock pin
	logic [1:0] present, present_rise, present_fall;
	logic [4:0] sup_ok_raw, sup_ok_rise;    // Supply comparators
	logic [4:0] sup_fault_rise;             // Supply faults
	logic       oc_rise, boost_lvl, boost_rise;
	logic       oc_unused;                  // Over-current level, edge used
	logic [4:0] io_fall;                    // Answer start bits
	logic [3:0] aux_lvl;                    // Aux contacts from host

	// Bus and register state
	logic        addr_ok;                   // Accepted address phase
	logic        wr_pend_ff;                // Write data phase pending
	logic [7:0]  wr_addr_ff;                // Write offset
	logic [18:0] rd_clr_ff;                 // Flags reported by a read
	logic        rd_clr_pend_ff;            // Flag read in data phase
	logic [31:0] rdata;                     // Read mux
	logic [5:0]  ctrl_ff;                   // Masks and off bits
	logic [14:0] clksel_ff;                 // Clock source per slot
	logic [9:0]  slew_ff;                   // Slew mode per slot
	logic [16:0] supply_ff;                 // Supply selects, auto bits
	logic        soft_rst_ff;               // Reset command pulse
	logic        addr_pend_ff;              // Address latch pending
	logic [1:0]  addr_wait_ff;              // Synchroniser fill after reset

	// Flags and alert
	card_alert_pkg::flags_s flags_ff;       // Sticky event flags
	logic [18:0] set_vec;                   // Hardware and software sets
	logic [18:0] sw_set;                    // Software set this cycle
	logic [18:0] enable_vec;                // Alert enables per flag
	logic [3:0]  mask;                      // Slot 2..5 masks
	logic        alert_active_ff;           // Pin driven low

	// Status
	logic [4:0]  supply_good;
	logic        boost_good;

	// Card clock and answer counters
	logic [7:0]  div_ff;                    // Internal clock divider
	logic        int_clk_ff;                // Internal card clock
	logic        host_half_ff;              // Host clock halved
	logic [4:0]  card_clk_ff;               // Card clock outputs
	logic [4:0]  nxt_card_clk;
	logic [4:0]  answer_over;               // Counter overflow pulses

	// Pin synchronisers
	edge_sync #(.W(1)) u_sync_host (
		.clk(hclk), .rst_n(hresetn), .d(addr_or_host_clock_in),
		.lvl(host_lvl), .rise(host_rise), .fall());
	edge_sync #(.W(2)) u_sync_det (
		.clk(hclk), .rst_n(hresetn), .d(card_detect_in),
		.lvl(present), .rise(present_rise), .fall(present_fall));
	edge_sync #(.W(5)) u_sync_ok (
		.clk(hclk), .rst_n(hresetn), .d(supply_in_range),
		.lvl(sup_ok_raw), .rise(sup_ok_rise), .fall());
	edge_sync #(.W(5)) u_sync_flt (
		.clk(hclk), .rst_n(hresetn), .d(supply_fault_in),
		.lvl(), .rise(sup_fault_rise), .fall());
	edge_sync #(.W(2)) u_sync_b (
		.clk(hclk), .rst_n(hresetn),
		.d({slot1_overcurrent_in, boost_b_in_range}),
		.lvl({oc_unused, boost_lvl}), .rise({oc_rise, boost_rise}),
		.fall());
	edge_sync #(.W(5)) u_sync_io (
		.clk(hclk), .rst_n(hresetn), .d(card_io_line),
		.lvl(), .rise(), .fall(io_fall));
	edge_sync #(.W(4)) u_sync_aux (
		.clk(hclk), .rst_n(hresetn),
		.d({aux_host_b_in, aux_host_a_in}),
		.lvl(aux_lvl), .rise(), .fall());

	// Bus answers at once, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_ok   = hsel & htrans[1] & hready;

	// Read mux, unmapped offsets read zero
	always_comb
	begin
		rdata = 32'h0000_0000;
		unique case (haddr[7:0])
			`REG_FLAGS:  rdata = {13'h0000, flags_ff};
			`REG_STATUS: rdata = {21'h000000, alert_active_ff,
				regulator_off, bus_addr_bit, boost_good,
				supply_good, present};
			`REG_CTRL:   rdata = {26'h0000000, ctrl_ff};
			`REG_CLKSEL: rdata = {17'h00000, clksel_ff};
			`REG_SLEW:   rdata = {22'h000000, slew_ff};
			`REG_SUPPLY: rdata = {15'h0000, supply_ff};
			default:     rdata = 32'h0000_0000;
		endcase
	end

	// Address phase capture, read data registered for the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff     <= 1'b0;
			wr_addr_ff     <= 8'h00;
			hrdata         <= 32'h0000_0000;
			rd_clr_pend_ff <= 1'b0;
			rd_clr_ff      <= 19'h00000;
		end
		else
		begin
			wr_pend_ff     <= addr_ok & hwrite;
			wr_addr_ff     <= haddr[7:0];
			rd_clr_pend_ff <= addr_ok & ~hwrite &
				(haddr[7:0] == `REG_FLAGS);
			rd_clr_ff      <= flags_ff; // Only what was reported
			if (addr_ok & ~hwrite)
				hrdata <= rdata;
		end
	end

	// Writable configuration, cleared by reset command too
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_ff   <= `CTRL_RST;
			clksel_ff <= `CLKSEL_RST;
			slew_ff   <= `SLEW_RST;
			supply_ff <= `SUPPLY_RST;
		end
		else if (soft_rst_ff)
		begin
			ctrl_ff   <= `CTRL_RST;
			clksel_ff <= `CLKSEL_RST;
			slew_ff   <= `SLEW_RST;
			supply_ff <= `SUPPLY_RST;
		end
		else if (wr_pend_ff)
		begin
			unique case (wr_addr_ff)
				`REG_CTRL:   ctrl_ff   <= hwdata[5:0];
				`REG_CLKSEL: clksel_ff <= hwdata[14:0];
				`REG_SLEW:   slew_ff   <= hwdata[9:0];
				`REG_SUPPLY: supply_ff <= hwdata[16:0];
				default:     ;
			endcase
		end
	end

	// Reset command pulse, general call value behaves the same
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			soft_rst_ff <= 1'b0;
		else
			soft_rst_ff <= wr_pend_ff & (wr_addr_ff == `REG_CMD) &
				((hwdata[7:0] == `CMD_GEN_RESET) |
				 (hwdata[7:0] == `CMD_RESET));
	end

	// Address bit caught once the synchroniser holds the pin level
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_pend_ff <= 1'b1;
			addr_wait_ff <= `SYNC_FILL;
			bus_addr_bit <= 1'b0;
		end
		else if (soft_rst_ff)
			addr_pend_ff <= 1'b1;
		else if (addr_wait_ff != 2'h0)
			addr_wait_ff <= addr_wait_ff - 2'h1; // Reset emptied the chain
		else if (addr_pend_ff)
		begin
			addr_pend_ff <= 1'b0;
			bus_addr_bit <= host_lvl;
		end
	end

	// Software set strobe
	assign sw_set = (wr_pend_ff && wr_addr_ff == `REG_SWSET) ?
		hwdata[18:0] : 19'h00000;

	// Hardware events in flag order
	assign set_vec = sw_set | {answer_over,
		sup_fault_rise,
		oc_rise,
		boost_rise,
		sup_ok_rise & supply_good,
		present_rise | present_fall};

	// Sticky flags, set wins over a read clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flags_ff <= '0;
		else if (soft_rst_ff)
			flags_ff <= '0;
		else if (rd_clr_pend_ff)
			flags_ff <= (flags_ff & ~rd_clr_ff) | set_vec;
		else
			flags_ff <= flags_ff | set_vec;
	end

	// Masks gate slots 2..5 only
	assign mask = ctrl_ff[`CTRL_MASK_LSB +: 4];
	assign enable_vec = ~{mask, 1'b0, mask, 1'b0, 1'b0, 1'b0,
		mask, 1'b0, mask[0], 1'b0};

	// Alert state, low while any enabled flag stands
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			alert_active_ff <= 1'b0;
		else
			alert_active_ff <= |(flags_ff & enable_vec);
	end

	// Open drain: drive low or release
	assign alert_n_o  = 1'b0;
	assign alert_oe_n = ~alert_active_ff;

	// Status levels
	always_comb
	begin
		for (int i = 0; i < 5; i++)
			supply_good[i] = sup_ok_raw[i] &
				(supply_ff[2*i +: 2] != 2'h0);
		boost_good = boost_lvl &
			(supply_ff[`SUP_BOOST_LSB +: 2] != 2'h0);
	end

	// Supply and power-down outputs
	assign supply_select_field  = supply_ff[`SUP_SEL_LSB +: 10];
	assign boost_b_select_field = supply_ff[`SUP_BOOST_LSB +: 2];
	assign conv_a_off    = ctrl_ff[`CTRL_CONV_A_BIT];
	assign conv_b_off    = ctrl_ff[`CTRL_CONV_B_BIT];
	assign regulator_off = conv_a_off & conv_b_off;

	// Internal card clock and halved host clock
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_ff       <= 8'h00;
			int_clk_ff   <= 1'b0;
			host_half_ff <= 1'b0;
		end
		else
		begin
			if (div_ff == 8'(CARD_DIV - 1))
			begin
				div_ff     <= 8'h00;
				int_clk_ff <= ~int_clk_ff;
			end
			else
				div_ff <= div_ff + 8'h01;
			if (host_rise)
				host_half_ff <= ~host_half_ff;
		end
	end

	// Per-slot clock routing, slew and answer counter
	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : g_slot
			logic [15:0] cnt_ff;   // Card clocks since arming
			logic        done_ff;  // Start bit seen or overflow
			logic        armed;    // Automatic answer mode active

			// Source choice, slots 3..5 included
			always_comb
			begin
				unique case (card_alert_pkg::clk_source_e'(
					clksel_ff[3*g +: 3]))
					card_alert_pkg::CLK_INTERNAL:
						nxt_card_clk[g] = int_clk_ff;
					card_alert_pkg::CLK_HOST:
						nxt_card_clk[g] = host_lvl;
					card_alert_pkg::CLK_HOST_HALF:
						nxt_card_clk[g] = host_half_ff;
					default:
						nxt_card_clk[g] = 1'b0;
				endcase
			end

			assign armed = supply_ff[`SUP_AUTO_LSB + g] & supply_good[g];

			// Count card clock rises until start bit or overflow
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					cnt_ff  <= 16'h0000;
					done_ff <= 1'b0;
				end
				else if (!armed)
				begin
					cnt_ff  <= 16'h0000;
					done_ff <= 1'b0;
				end
				else if (!done_ff)
				begin
					if (io_fall[g])
						done_ff <= 1'b1;
					else if (answer_over[g])
						done_ff <= 1'b1;
					else if (nxt_card_clk[g] & ~card_clk_ff[g])
						cnt_ff <= cnt_ff + 16'h0001;
				end
			end

			assign answer_over[g] = armed & ~done_ff & ~io_fall[g] &
				(cnt_ff == 16'(ANSWER_LIMIT));

			slew_select u_slew (
				.clk         (hclk),
				.rst_n       (hresetn),
				.mode        (slew_ff[2*g +: 2]),
				.supply_sel  (supply_ff[2*g +: 2]),
				.clk_code    (clk_slew_code[2*g +: 2]),
				.io_rise_code(io_rise_slew_code[2*g +: 2]));
		end
	endgenerate

	// Card clock and aux outputs from flops
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			card_clk_ff   <= 5'h00;
			aux_contact_a <= 2'h0;
			aux_contact_b <= 2'h0;
		end
		else
		begin
			card_clk_ff   <= nxt_card_clk;
			aux_contact_a <= aux_lvl[1:0];
			aux_contact_b <= aux_lvl[3:2];
		end
	end

	assign card_clock_line = card_clk_ff;

	// Checks
	property p_alert_follows;
		@(posedge hclk) disable iff (!hresetn)
		##1 alert_oe_n == !$past(|(flags_ff & enable_vec));
	endproperty
	a_alert_follows: assert property (p_alert_follows)
		else $error("alert pin does not follow enabled flags");

	property p_release_when_clear;
		@(posedge hclk) disable iff (!hresetn)
		(flags_ff == '0) |=> alert_oe_n;
	endproperty
	a_release_when_clear: assert property (p_release_when_clear)
		else $error("alert held low with no flag set");

	property p_masked_quiet;
		@(posedge hclk) disable iff (!hresetn)
		(mask == 4'hf) && ((flags_ff & ~19'h7bc7a) == '0) |=> alert_oe_n;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet)
		else $error("masked slot flag pulled alert low");

	property p_read_clears;
		@(posedge hclk) disable iff (!hresetn)
		(rd_clr_pend_ff && !soft_rst_ff) |=>
			((flags_ff & $past(rd_clr_ff) & ~$past(set_vec)) == '0);
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("reported flag survived its read");

	property p_card_change;
		@(posedge hclk) disable iff (!hresetn)
		(present_rise[0] | present_fall[0]) && !soft_rst_ff
			|=> flags_ff.card_change_flag[0];
	endproperty
	a_card_change: assert property (p_card_change)
		else $error("card change not flagged");

	property p_answer_error;
		@(posedge hclk) disable iff (!hresetn)
		answer_over[0] && !soft_rst_ff |=> flags_ff.answer_error_flag[0];
	endproperty
	a_answer_error: assert property (p_answer_error)
		else $error("counter overflow not flagged");

	property p_regulator;
		@(posedge hclk) disable iff (!hresetn)
		regulator_off == (conv_a_off && conv_b_off);
	endproperty
	a_regulator: assert property (p_regulator)
		else $error("regulator power-down mismatch");

	property p_stay_down;
		@(posedge hclk) disable iff (!hresetn)
		$fell(regulator_off) |->
			$past(wr_pend_ff && wr_addr_ff == `REG_CTRL);
	endproperty
	a_stay_down: assert property (p_stay_down)
		else $error("power-down left without a write");

	property p_addr_latch;
		@(posedge hclk) disable iff (!hresetn)
		addr_pend_ff && addr_wait_ff == 2'h0 && !soft_rst_ff |=>
			!addr_pend_ff && bus_addr_bit == $past(host_lvl);
	endproperty
	a_addr_latch: assert property (p_addr_latch)
		else $error("address bit not caught from pin");

	property p_cmd_reset;
		@(posedge hclk) disable iff (!hresetn)
		soft_rst_ff |=> flags_ff == '0 && addr_pend_ff ##1 !addr_pend_ff;
	endproperty
	a_cmd_reset: assert property (p_cmd_reset)
		else $error("reset command did not clear and relatch");

endmodule // card_interrupt_status_logic

// ---- rtl/card_alert_defs.svh ----
// Purpose: Offsets, field positions, reset values and counts
// Assumes: Word-aligned register map on a 32-bit bus
// Notes:   Included by the bus-facing module and the testbench
`ifndef CARD_ALERT_DEFS_SVH
`define CARD_ALERT_DEFS_SVH

// Register byte offsets
`define REG_FLAGS        8'h00
`define REG_STATUS       8'h04
`define REG_CTRL         8'h08
`define REG_CLKSEL       8'h0c
`define REG_SLEW         8'h10
`define REG_SUPPLY       8'h14
`define REG_SWSET        8'h18
`define REG_CMD          8'h1c

// Control register fields
`define CTRL_MASK_LSB    0
`define CTRL_CONV_A_BIT  4
`define CTRL_CONV_B_BIT  5

// Supply register fields
`define SUP_SEL_LSB      0
`define SUP_BOOST_LSB    10
`define SUP_AUTO_LSB     12

// Status register fields
`define ST_ADDR_BIT      8
`define ST_REG_OFF_BIT   9
`define ST_ALERT_BIT     10

// Command values
`define CMD_GEN_RESET    8'h06
`define CMD_RESET        8'hff

// Reset values
`define CTRL_RST         6'h00
`define CLKSEL_RST       15'h0000
`define SLEW_RST         10'h000
`define SUPPLY_RST       17'h00000

// Timing counts
`define ANSWER_LIMIT     65535
`define CARD_CLK_DIV     2
`define SYNC_FILL        2'h2

`endif

// ---- rtl/card_alert_pkg.sv ----
// Purpose: Types shared by the alert and status logic
// Assumes: Five slots, two of them with presence detect
// Notes:   Flag struct packs into the low bits of the flag word
package card_alert_pkg;

	// Event flags, card change in bit 0 upward
	typedef struct packed {
		logic [4:0] answer_error_flag;
		logic [4:0] supply_error_flag;
		logic       slot1_overcurrent_flag;
		logic       boost_b_settled_flag;
		logic [4:0] supply_settled_flag;
		logic [1:0] card_change_flag;
	} flags_s;

	// Card clock source per slot
	typedef enum logic [2:0] {
		CLK_INTERNAL  = 3'h0,
		CLK_HOST      = 3'h1,
		CLK_HOST_HALF = 3'h3,
		CLK_STOPPED   = 3'h2
	} clk_source_e;

	// Slew rate modes
	typedef enum logic [1:0] {
		SLEW_AUTO = 2'h0,
		SLEW_1V8  = 2'h1,
		SLEW_3V   = 2'h2,
		SLEW_5V   = 2'h3
	} slew_mode_e;

endpackage

// ---- rtl/edge_sync.sv ----
// Purpose: Two-stage synchroniser with edge detection
// Assumes: Inputs asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module edge_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Asynchronous input
	input  wire logic [W-1:0] d,
	// Synchronised level and edges
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] meta_ff; // First stage
	logic [W-1:0] sync_ff; // Second stage
	logic [W-1:0] prev_ff; // Previous synced value

	// Shift chain
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end
		else
		begin
			meta_ff <= d;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign lvl  = sync_ff;
	assign rise = sync_ff & ~prev_ff;
	assign fall = ~sync_ff & prev_ff;

endmodule // edge_sync

// ---- rtl/slew_select.sv ----
// Purpose: Slew code choice for one slot
// Assumes: Supply select 01=1.8V, 10=3V, 11=5V, 00=off
// Notes:   Card data falling edge is never slew limited
`timescale 1ns/1ps
module slew_select (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Mode and supply level
	input  wire logic [1:0] mode,
	input  wire logic [1:0] supply_sel,
	// Drive codes
	output logic      [1:0] clk_code,
	output logic      [1:0] io_rise_code
);

	logic [1:0] nxt_code; // Chosen code

	// Automatic follows supply, forced modes override it
	always_comb
	begin
		nxt_code = mode;
		if (mode == card_alert_pkg::SLEW_AUTO)
			nxt_code = (supply_sel == 2'h0) ? 2'h3 : supply_sel;
	end

	// Same code on both clock edges and the data rising edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_code     <= 2'h3;
			io_rise_code <= 2'h3;
		end
		else
		begin
			clk_code     <= nxt_code;
			io_rise_code <= nxt_code;
		end
	end

endmodule // slew_select

// ---- testbench/card_far_side.sv ----
// Purpose: Card-side comparators and data lines seen by the block
// Assumes: A chosen level settles three hclk after it is set
// Notes:   Data lines rest on pull-ups; no card ever answers
`timescale 1ns/1ps
module card_far_side (
	// Clock
	input  wire logic       hclk,
	// Levels chosen by the block
	input  wire logic [9:0] supply_select_field,
	input  wire logic [1:0] boost_b_select_field,
	// Comparator results and card data
	output logic      [4:0] supply_in_range,
	output logic            boost_b_in_range,
	output logic      [4:0] card_io_line
);
	logic [5:0] on_now;     // Levels chosen this cycle
	logic [5:0] st [3];     // Settling pipeline
	// Pull-ups hold idle data lines high
	assign card_io_line = 5'h1f;
	// Comparator sees a level once one is chosen
	always_comb
	begin
		on_now[5] = |boost_b_select_field;
		for (int i = 0; i < 5; i++)
			on_now[i] = |supply_select_field[2*i+:2];
	end
	// Settling delay
	initial st = '{default: 6'h0};
	always @(posedge hclk)
	begin
		st[0] <= on_now;
		st[1] <= st[0];
		st[2] <= st[1];
	end
	assign {boost_b_in_range, supply_in_range} = st[2];
endmodule // card_far_side

// ---- testbench/tb_card_interrupt_status_logic.sv ----
// Purpose: Self-checking bench for alert, status and power-down
// Assumes: Zero-wait slave, answer limit cut to 20 card clocks
// Notes:   Reads queue their expected word for the monitor
`timescale 1ns/1ps
`include "card_alert_defs.svh"
module tb_card_interrupt_status_logic;
	logic        hclk, hresetn, hsel, hwrite, rd_dp;
	logic        host_pin, host_run, pin_lvl, alert_line;
	logic        hreadyout, hresp, alert_n_o, alert_oe_n;
	logic        regulator_off, conv_a_off, conv_b_off;
	logic        boost_b_in_range, bus_addr_bit;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [1:0]  htrans, card_detect_in, boost_b_select_field;
	logic [2:0]  hsize;
	logic [4:0]  supply_in_range, card_io_line, card_clock_line;
	logic [9:0]  clk_slew_code, io_rise_slew_code, supply_select_field;
	logic [31:0] exp_q [$];  // Expected read words
	logic [3:0]  aux_in, aux_out;  // Host aux levels and card copies
	logic [4:0]  fault_in;         // Supply fault pins
	logic        oc_in;            // Over-current pin
	int          fail_count, n_compared, seed, n0, n2;
	// Block under test
	card_interrupt_status_logic #(.ANSWER_LIMIT(20), .CARD_DIV(2)) i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.addr_or_host_clock_in(host_pin), .card_detect_in,
		.supply_in_range, .supply_fault_in(fault_in),
		.slot1_overcurrent_in(oc_in), .boost_b_in_range, .card_io_line,
		.aux_host_a_in(aux_in[1:0]), .aux_host_b_in(aux_in[3:2]),
		.alert_n_o, .alert_oe_n, .card_clock_line,
		.aux_contact_a(aux_out[1:0]), .aux_contact_b(aux_out[3:2]),
		.clk_slew_code, .io_rise_slew_code,
		.supply_select_field, .boost_b_select_field, .conv_a_off,
		.conv_b_off, .regulator_off, .bus_addr_bit);
	// Comparators on the card side
	card_far_side i_far (.hclk, .supply_select_field,
		.boost_b_select_field, .supply_in_range, .boost_b_in_range,
		.card_io_line);
	// Pull-up on the shared alert line
	assign alert_line = alert_oe_n ? 1'b1 : alert_n_o;
	// Clocks: system, and host clock on the shared pin
	initial
	begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	initial
	begin
		#7;
		forever #160 host_pin = host_run ? ~host_pin : pin_lvl;
	end
	always @(posedge card_clock_line[0]) n0++;
	always @(posedge card_clock_line[2]) n2++;
	// Compare one value
	task chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Monitor: read data against oldest note
	always @(posedge hclk)
		if (rd_dp)
			chk("hrdata", hrdata, exp_q.pop_front());
	// Wait and settle
	task tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	// One single AHB-Lite word transfer
	task xfer(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		rd_dp <= ~w;
		if (!w)
			exp_q.push_back(d);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask
	// Verdict and end
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (5000) @(posedge hclk);
		fail_count++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		{hresetn, hwrite, rd_dp, host_run, n0, n2} = '0;
		{haddr, hwdata, htrans, card_detect_in} = '0;
		{fault_in, oc_in, aux_in} = '0;
		{hsel, pin_lvl, host_pin, hsize, seed} = {3'h7, 3'h2, 32'h3999};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(0, `REG_FLAGS, 0);
		xfer(0, `REG_STATUS, 32'h100);
		xfer(0, 8'h20, 0);
		chk("alert", alert_line, 1);
		chk("resp", {hresp, hreadyout}, 2'h1);
		chk("slew", {clk_slew_code, io_rise_slew_code}, 20'hfffff);
		$display("reset test done");
		repeat (3)
		begin
			v = ($random(seed) & 32'h7ffff) | 32'h1;
			xfer(1, `REG_SWSET, v);
			tick(2);
			chk("alert", alert_line, 0);
			xfer(0, `REG_FLAGS, v);
			tick(2);
			chk("alert", alert_line, 1);
			xfer(0, `REG_FLAGS, 0);
		end
		$display("flag test done");
		xfer(1, `REG_CTRL, 32'hf);
		xfer(1, `REG_SWSET, 32'h40002);
		tick(3);
		chk("alert", alert_line, 1);
		xfer(0, `REG_FLAGS, 32'h40002);
		xfer(1, `REG_SWSET, 32'h100);
		tick(3);
		chk("alert", alert_line, 0);
		xfer(0, `REG_FLAGS, 32'h100);
		xfer(1, `REG_CTRL, 32'h30);
		tick(1);
		chk("off", {regulator_off, conv_a_off, conv_b_off}, 3'h7);
		xfer(0, `REG_STATUS, 32'h300);
		xfer(1, `REG_CTRL, 32'h10);
		tick(1);
		chk("off", regulator_off, 0);
		xfer(1, `REG_CTRL, 0);
		$display("mask and power test done");
		@(posedge hclk);
		card_detect_in <= 2'h1;
		tick(8);
		xfer(0, `REG_STATUS, 32'h501);
		xfer(0, `REG_FLAGS, 32'h1);
		xfer(1, `REG_SUPPLY, 32'h1402);
		tick(12);
		xfer(0, `REG_STATUS, 32'h585);
		chk("slew", clk_slew_code[1:0], 2'h2);
		tick(120);
		xfer(0, `REG_FLAGS, 32'h4084);
		for (int m = 1; m < 4; m++)
		begin
			xfer(1, `REG_SLEW, 32'(m));
			tick(2);
			chk("slew", clk_slew_code[1:0], m[1:0]);
			chk("rise", io_rise_slew_code[1:0], m[1:0]);
		end
		@(posedge hclk);
		fault_in <= 5'h04;
		oc_in <= 1'b1;
		aux_in <= 4'($random(seed));
		tick(6);
		chk("alert", alert_line, 0);
		chk("aux", aux_out, aux_in);
		xfer(0, `REG_FLAGS, 32'h900);
		$display("supply test done");
		xfer(1, `REG_CLKSEL, 32'h41);
		host_run <= 1'b1;
		tick(8);
		{n0, n2} = '0;
		tick(80);
		chk("host", n0 > 8 && n0 < 12 && n2 > 8 && n2 < 12, 1);
		host_run <= 1'b0;
		pin_lvl <= 1'b0;
		tick(12);
		xfer(1, `REG_CMD, 32'h6);
		tick(6);
		chk("addr", bus_addr_bit, 0);
		xfer(0, `REG_SUPPLY, 0);
		xfer(0, `REG_CLKSEL, 0);
		$display("clock and command test done");
		complete_run();
	end
endmodule // tb_card_interrupt_status_logic
